// file: logic/pocr_regs.v
// Output control command registers of a dual-channel regulator controller
`timescale 1ns/1ps
`default_nettype none
`include "pocr_map.vh"
module pocr_regs #(
  parameter STORE_CYCLES = `POCR_STORE_CYCLES
) (
  input wire core_clk,
  input wire rst,
  input wire nvm_clear,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  input wire [1:0] loop_scale_sel,
  input wire [1:0] channel_enable_pin,
  input wire [1:0] chan_slave,
  input wire [1:0] chan_fault,
  input wire [7:0] status_event,
  output reg cmd_ack,
  output reg [15:0] cmd_rdata,
  output reg cmd_busy,
  output reg alert_n,
  output reg vid_mode,
  output wire [1:0] chan_on,
  output wire [1:0] chan_soft_off,
  output wire [31:0] chan_setpoint,
  output wire [23:0] chan_vid_mv
);
  localparam [7:0] CFG_DEFAULT = `POCR_RST_CFG;
  wire [13:0] sync_bus;
  wire [1:0] en_s, slave_s, fault_s, clear_req;
  wire [7:0] event_s;
  reg both_channel_select, channel_index_select, init_done;
  reg [7:0] wp, mode, mask, status, nv_mode, nv_mask, next_status;
  reg [24:0] store_cnt;
  reg [7:0] op_r [0:1], cfg_r [0:1];
  reg [15:0] vout_r [0:1];
  reg on_a [0:1], soft_a [0:1];
  reg [11:0] mv_a [0:1];
  wire cmd_go, wr, rd, rd_ch, clear_cmd, restore_cmd, store_cmd;
  reg [15:0] next_rdata;

  pocr_sync #(.WIDTH(14)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({status_event, chan_fault, chan_slave, channel_enable_pin}),
    .sync_out(sync_bus)
  );
  assign en_s = sync_bus[1:0];
  assign slave_s = sync_bus[3:2];
  assign fault_s = sync_bus[5:4];
  assign event_s = sync_bus[13:6];

  // Write permission of a command under a protection value
  function wr_ok;
    input [7:0] code;
    input [7:0] prot;
    begin
      if (prot[`POCR_WP_B7]) begin
        wr_ok = (code == `POCR_CMD_WP);
      end else if (prot[`POCR_WP_B6]) begin
        wr_ok = (code == `POCR_CMD_WP) || (code == `POCR_CMD_PAGE) ||
                (code == `POCR_CMD_OPER);
      end else if (prot[`POCR_WP_B5]) begin
        wr_ok = (code == `POCR_CMD_WP) || (code == `POCR_CMD_PAGE) ||
                (code == `POCR_CMD_OPER) || (code == `POCR_CMD_CFG) ||
                (code == `POCR_CMD_VOUT);
      end else begin
        wr_ok = 1'b1;
      end
    end
  endfunction

  // Setpoint validity for the current format and loop scale
  function vout_ok;
    input [15:0] val;
    input [7:0] fmt;
    input [1:0] scale;
    begin
      if (fmt == `POCR_MODE_VID) begin
        vout_ok = (val[15:8] == 8'h00);
      end else begin
        case (scale)
          `POCR_SCALE_1: vout_ok = (val >= `POCR_LIN1_MIN) && (val <= `POCR_LIN1_MAX);
          `POCR_SCALE_HALF: vout_ok = (val >= `POCR_LIN2_MIN) && (val <= `POCR_LIN2_MAX);
          `POCR_SCALE_QUARTER: vout_ok = (val >= `POCR_LIN4_MIN) && (val <= `POCR_LIN4_MAX);
          default: vout_ok = 1'b0;
        endcase
      end
    end
  endfunction

  // Store keeps the command port deaf until it completes
  assign cmd_go = cmd_valid & ~cmd_busy;
  assign wr = cmd_go & cmd_write;
  assign rd = cmd_go & ~cmd_write;
  assign clear_cmd = wr & (cmd_code == `POCR_CMD_CLEAR);
  assign store_cmd = wr & (cmd_code == `POCR_CMD_STORE);
  assign restore_cmd = wr & (cmd_code == `POCR_CMD_RESTORE);
  // Reads use channel 0 when both selected
  assign rd_ch = both_channel_select ? 1'b0 : channel_index_select;

  // Global registers, status, store timer and read port
  always @* begin
    next_status = status;
    if (clear_cmd | (|clear_req)) begin
      next_status = `POCR_RST_STATUS;
    end
    if (!cmd_busy) begin
      next_status = next_status | event_s;
    end
  end

  always @* begin
    next_rdata = 16'h0000;
    case (cmd_code)
      `POCR_CMD_PAGE: next_rdata = {8'h00, both_channel_select, 6'h00, channel_index_select};
      `POCR_CMD_OPER: next_rdata = {8'h00, op_r[rd_ch]};
      `POCR_CMD_CFG: next_rdata = {8'h00, cfg_r[rd_ch]};
      `POCR_CMD_WP: next_rdata = {8'h00, wp};
      `POCR_CMD_CAP: next_rdata = {8'h00, `POCR_RST_CAP};
      `POCR_CMD_MASK: next_rdata = {mask, `POCR_CMD_STATUS};
      `POCR_CMD_MODE: next_rdata = {8'h00, mode};
      `POCR_CMD_VOUT: next_rdata = vout_r[rd_ch];
      `POCR_CMD_STATUS: next_rdata = {8'h00, status};
      default: next_rdata = 16'h0000;
    endcase
  end

  always @(posedge core_clk or posedge nvm_clear) begin
    if (nvm_clear) begin
      nv_mode <= `POCR_RST_MODE;
      nv_mask <= `POCR_RST_MASK;
    end else if (store_cmd) begin
      nv_mode <= mode;
      nv_mask <= mask;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      both_channel_select <= 1'b0;
      channel_index_select <= 1'b0;
      wp <= `POCR_RST_WP;
      mode <= `POCR_RST_MODE;
      mask <= `POCR_RST_MASK;
      status <= `POCR_RST_STATUS;
      store_cnt <= 25'h0000000;
      init_done <= 1'b0;
      cmd_ack <= 1'b0;
      cmd_rdata <= 16'h0000;
      cmd_busy <= 1'b0;
      alert_n <= 1'b1;
      vid_mode <= 1'b0;
    end else begin
      init_done <= 1'b1;
      cmd_ack <= cmd_go;
      if (rd) begin
        cmd_rdata <= next_rdata;
      end
      status <= next_status;
      // Masked bits never raise the alert
      alert_n <= ~|(next_status & ~mask);
      vid_mode <= (mode == `POCR_MODE_VID);
      if (store_cmd) begin
        cmd_busy <= 1'b1;
        store_cnt <= STORE_CYCLES[24:0] - 25'h0000001;
      end else if (store_cnt != 25'h0000000) begin
        store_cnt <= store_cnt - 25'h0000001;
      end else begin
        cmd_busy <= 1'b0;
      end
      if (!init_done) begin
        mode <= nv_mode;
        mask <= nv_mask;
      end else if (restore_cmd) begin
        if (wr_ok(`POCR_CMD_MODE, wp)) begin
          mode <= nv_mode;
        end
        if (wr_ok(`POCR_CMD_MASK, wp)) begin
          mask <= nv_mask;
        end
      end else if (wr && wr_ok(cmd_code, wp)) begin
        case (cmd_code)
          `POCR_CMD_PAGE: begin
            if (!(cmd_wdata[`POCR_PAGE_BOTH] && !cmd_wdata[`POCR_PAGE_IDX])) begin
              both_channel_select <= cmd_wdata[`POCR_PAGE_BOTH];
              channel_index_select <= cmd_wdata[`POCR_PAGE_IDX];
            end
          end
          `POCR_CMD_WP: begin
            if ((cmd_wdata[`POCR_WP_B5] + cmd_wdata[`POCR_WP_B6] +
                 cmd_wdata[`POCR_WP_B7]) <= 2'h1) begin
              wp <= cmd_wdata[7:0] & `POCR_WP_MASK;
            end
          end
          `POCR_CMD_MODE: begin
            if ((cmd_wdata[7:0] == `POCR_MODE_LINEAR) || (cmd_wdata[7:0] == `POCR_MODE_VID)) begin
              mode <= cmd_wdata[7:0];
            end
          end
          `POCR_CMD_MASK: begin
            if (cmd_wdata[7:0] == `POCR_CMD_STATUS) begin
              mask <= cmd_wdata[15:8];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Per-channel control, configuration, setpoint and power-up logic
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      reg [7:0] nv_op, nv_cfg;
      reg [15:0] nv_vout;
      reg pol_eff, off_seen, latched, clr_pulse;
      wire sel, wr_ch, en_act, want, on_next, soft_next;
      wire [11:0] vid_code;

      assign sel = both_channel_select | (channel_index_select == ch);
      // Slave channel writes have no effect
      assign wr_ch = wr & sel & ~slave_s[ch] & wr_ok(cmd_code, wp);
      assign clear_req[ch] = clr_pulse;
      // Polarity from the power-up copy only
      assign en_act = pol_eff ? en_s[ch] : ~en_s[ch];
      // On bit heeded only when enabled
      assign want = ~cfg_r[ch][`POCR_CFG_PU] |
                    ((~cfg_r[ch][`POCR_CFG_CMD] | op_r[ch][`POCR_OP_ON]) &
                     (~cfg_r[ch][`POCR_CFG_CTRL] | en_act));
      // Latched fault holds the channel off
      assign on_next = want & ~latched & init_done;
      assign soft_next = (cfg_r[ch][`POCR_CFG_CMD] & ~op_r[ch][`POCR_OP_ON]) ?
                         op_r[ch][`POCR_OP_SOFT] :
                         ((cfg_r[ch][`POCR_CFG_CTRL] & ~en_act) ? ~cfg_r[ch][`POCR_CFG_OFF] : 1'b0);
      assign vid_code = {4'h0, vout_r[ch][7:0]};

      always @(posedge core_clk or posedge nvm_clear) begin
        if (nvm_clear) begin
          nv_op <= `POCR_RST_OPER;
          nv_cfg <= `POCR_RST_CFG;
          nv_vout <= `POCR_RST_VOUT;
        end else if (store_cmd) begin
          nv_op <= op_r[ch];
          nv_cfg <= cfg_r[ch];
          nv_vout <= vout_r[ch];
        end
      end

      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          op_r[ch] <= `POCR_RST_OPER;
          cfg_r[ch] <= `POCR_RST_CFG;
          vout_r[ch] <= `POCR_RST_VOUT;
          pol_eff <= CFG_DEFAULT[`POCR_CFG_POL];
          off_seen <= 1'b0;
          latched <= 1'b0;
          clr_pulse <= 1'b0;
          on_a[ch] <= 1'b0;
          soft_a[ch] <= 1'b0;
          mv_a[ch] <= 12'h000;
        end else begin
          clr_pulse <= 1'b0;
          latched <= (fault_s[ch] & ~cmd_busy) | (latched & ~clr_pulse);
          // Output follows the gated on request
          on_a[ch] <= on_next;
          soft_a[ch] <= on_next ? 1'b0 : soft_next;
          // 250 mV at code 1, 5 mV per code
          if (vid_mode && (vid_code != 12'h000)) begin
            mv_a[ch] <= `POCR_VID_BASE_MV + `POCR_VID_STEP_MV * (vid_code - 12'h001);
          end else begin
            mv_a[ch] <= 12'h000;
          end
          if (!init_done) begin
            op_r[ch] <= nv_op;
            cfg_r[ch] <= nv_cfg;
            vout_r[ch] <= nv_vout;
            pol_eff <= nv_cfg[`POCR_CFG_POL];
          end else if (restore_cmd) begin
            if (wr_ok(`POCR_CMD_OPER, wp)) begin
              op_r[ch] <= nv_op;
            end
            if (wr_ok(`POCR_CMD_CFG, wp)) begin
              cfg_r[ch] <= nv_cfg;
            end
            if (wr_ok(`POCR_CMD_VOUT, wp)) begin
              vout_r[ch] <= nv_vout;
            end
          end else if (wr_ch) begin
            case (cmd_code)
              `POCR_CMD_OPER: begin
                op_r[ch] <= cmd_wdata[7:0] & `POCR_OPER_MASK;
                if (!cmd_wdata[`POCR_OP_ON]) begin
                  off_seen <= 1'b1;
                end else begin
                  off_seen <= 1'b0;
                  clr_pulse <= off_seen;
                end
              end
              `POCR_CMD_CFG: cfg_r[ch] <= cmd_wdata[7:0] & `POCR_CFG_MASK;
              `POCR_CMD_VOUT: begin
                if (vout_ok(cmd_wdata, mode, loop_scale_sel)) begin
                  vout_r[ch] <= cmd_wdata;
                end
              end
              default: ;
            endcase
          end
        end
      end
    end
  endgenerate

  assign chan_on = {on_a[1], on_a[0]};
  assign chan_soft_off = {soft_a[1], soft_a[0]};
  assign chan_setpoint = {vout_r[1], vout_r[0]};
  assign chan_vid_mv = {mv_a[1], mv_a[0]};
endmodule // pocr_regs
`default_nettype wire

// file: logic/pocr_map.vh
// Command codes, field positions, reset values and timing of the output control registers
`ifndef POCR_MAP_VH
`define POCR_MAP_VH
`define POCR_CMD_PAGE 8'h00
`define POCR_CMD_OPER 8'h01
`define POCR_CMD_CFG 8'h02
`define POCR_CMD_CLEAR 8'h03
`define POCR_CMD_WP 8'h10
`define POCR_CMD_STORE 8'h11
`define POCR_CMD_RESTORE 8'h12
`define POCR_CMD_CAP 8'h19
`define POCR_CMD_MASK 8'h1b
`define POCR_CMD_MODE 8'h20
`define POCR_CMD_VOUT 8'h21
`define POCR_CMD_STATUS 8'h7a
`define POCR_RST_OPER 8'h80
`define POCR_RST_CFG 8'h1e
`define POCR_RST_WP 8'h00
`define POCR_RST_CAP 8'hd0
`define POCR_RST_MASK 8'h00
`define POCR_RST_MODE 8'h17
`define POCR_RST_VOUT 16'h0133
`define POCR_RST_STATUS 8'h00
`define POCR_MODE_LINEAR 8'h17
`define POCR_MODE_VID 8'h21
`define POCR_OP_ON 7
`define POCR_OP_SOFT 6
`define POCR_CFG_PU 4
`define POCR_CFG_CMD 3
`define POCR_CFG_CTRL 2
`define POCR_CFG_POL 1
`define POCR_CFG_OFF 0
`define POCR_WP_B5 5
`define POCR_WP_B6 6
`define POCR_WP_B7 7
`define POCR_PAGE_BOTH 7
`define POCR_PAGE_IDX 0
`define POCR_PAGE_MASK 8'h81
`define POCR_OPER_MASK 8'hc0
`define POCR_CFG_MASK 8'h1f
`define POCR_WP_MASK 8'he0
`define POCR_SCALE_1 2'b00
`define POCR_SCALE_HALF 2'b01
`define POCR_SCALE_QUARTER 2'b10
`define POCR_LIN1_MIN 16'h00cd
`define POCR_LIN1_MAX 16'h0300
`define POCR_LIN2_MIN 16'h019a
`define POCR_LIN2_MAX 16'h0600
`define POCR_LIN4_MIN 16'h0334
`define POCR_LIN4_MAX 16'h0c00
`define POCR_VID_BASE_MV 12'h0fa
`define POCR_VID_STEP_MV 12'h005
`define POCR_STORE_MS 100
`define POCR_CLK_MHZ 200
`define POCR_STORE_CYCLES (`POCR_STORE_MS * 1000 * `POCR_CLK_MHZ)
`endif

// file: logic/pocr_sync.v
// Two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/1ps
`default_nettype none
module pocr_sync #(
  parameter WIDTH = 1
) (
  input wire core_clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // pocr_sync
`default_nettype wire

// file: bench/pocr_monitor.sv
// Assertion checker on the ports of the output control registers
`timescale 1ns/1ps
`default_nettype none
module pocr_monitor #(
  parameter STORE_CYCLES = 20
) (
  input wire core_clk,
  input wire rst,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [1:0] chan_fault,
  input wire [7:0] status_event,
  input wire cmd_ack,
  input wire [15:0] cmd_rdata,
  input wire cmd_busy,
  input wire alert_n,
  input wire vid_mode,
  input wire [1:0] chan_on
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  wire take = cmd_valid && !cmd_busy;
  wire fmt_wr = take && cmd_write && (cmd_code == 8'h20 || cmd_code == 8'h12);
  wire clr = take && cmd_write && cmd_code == 8'h03;
  property p_ack; take |=> cmd_ack; endproperty
  a_ack: assert property (p_ack)
    else $error("command not acknowledged");
  property p_spur; !cmd_valid |=> !cmd_ack; endproperty
  a_spur: assert property (p_spur)
    else $error("acknowledge without a command");
  property p_refuse; cmd_valid && cmd_busy |=> !cmd_ack; endproperty
  a_refuse: assert property (p_refuse)
    else $error("command answered during store");
  property p_store; take && cmd_write && cmd_code == 8'h11 |=> cmd_busy [*8]; endproperty
  a_store: assert property (p_store)
    else $error("store did not hold busy");
  property p_vid; $rose(vid_mode) |-> $past(fmt_wr) || $past(fmt_wr, 2); endproperty
  a_vid: assert property (p_vid)
    else $error("format changed without a format write");
  property p_clear;
    (status_event == 8'h00 && chan_fault == 2'b00) [*4] ##0 clr |-> ##2 alert_n;
  endproperty
  a_clear: assert property (p_clear)
    else $error("alert held after clear faults");
  property p_hold; !cmd_ack |-> $stable(cmd_rdata); endproperty
  a_hold: assert property (p_hold)
    else $error("read data changed without a read");
  property p_cap; take && !cmd_write && cmd_code == 8'h19 |=> cmd_rdata == 16'h00d0; endproperty
  a_cap: assert property (p_cap)
    else $error("capability read wrong");
  property p_fault; (chan_fault[0] && !cmd_busy) [*5] |-> !chan_on[0]; endproperty
  a_fault: assert property (p_fault)
    else $error("channel runs during fault");
endmodule // pocr_monitor
bind pocr_regs pocr_monitor #(.STORE_CYCLES(STORE_CYCLES)) i_mon (.core_clk(core_clk),
  .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
  .chan_fault(chan_fault), .status_event(status_event), .cmd_ack(cmd_ack),
  .cmd_rdata(cmd_rdata), .cmd_busy(cmd_busy), .alert_n(alert_n), .vid_mode(vid_mode),
  .chan_on(chan_on));
`default_nettype wire

// file: bench/pocr_host.sv
// Host command master model for the output control registers
`timescale 1ns/1ps
`default_nettype none
module pocr_host (
  input wire core_clk,
  input wire cmd_ack,
  input wire cmd_busy,
  input wire [15:0] cmd_rdata,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  int gap = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // One command; ign sends it even while the store runs
  task req(input logic w, input logic [7:0] c, input logic [15:0] d, input bit ign,
           output logic [15:0] r, output bit a);
    int n;
    n = 0;
    @(negedge core_clk);
    while (cmd_busy && !ign && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    repeat (gap) @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    // Unqualified lines carry junk
    cmd_code = ~c;
    cmd_wdata = ~d;
    a = cmd_ack;
    r = cmd_rdata;
  endtask
  task restart();
    logic [15:0] r;
    bit a;
    req(1'b1, 8'h01, 16'h0000, 1'b0, r, a);
    req(1'b1, 8'h01, 16'h0080, 1'b0, r, a);
  endtask
endmodule // pocr_host
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench of the output control registers
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic nvm_clear = 1'b1;
  logic [1:0] loop_scale_sel = 2'b00;
  logic [1:0] channel_enable_pin = 2'b11;
  logic [1:0] chan_slave = 2'b00;
  logic [1:0] chan_fault = 2'b00;
  logic [7:0] status_event = 8'h00;
  wire cmd_valid, cmd_write, cmd_ack, cmd_busy, alert_n, vid_mode;
  wire [7:0] cmd_code;
  wire [15:0] cmd_wdata, cmd_rdata;
  wire [1:0] chan_on, chan_soft_off;
  wire [31:0] chan_setpoint;
  wire [23:0] chan_vid_mv;
  int failures = 0;
  int compares = 0;
  int pg, wp, fmt, scl;
  int op[2], cfg[2], vo[2];
  int nop[2], ncfg[2], nvo[2], nfmt;
  int cl[7] = '{0, 1, 2, 16, 25, 32, 33};
  int pv[7] = '{0, 0, 26, 0, 0, 33, 512};
  int cv[5] = '{14, 22, 26, 28, 30};
  int wl[3] = '{32, 64, 128};
  logic [15:0] lf = 16'hc4db;
  pocr_regs #(.STORE_CYCLES(20)) i_dut (.core_clk(core_clk), .rst(rst), .nvm_clear(nvm_clear),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .loop_scale_sel(loop_scale_sel), .channel_enable_pin(channel_enable_pin),
    .chan_slave(chan_slave), .chan_fault(chan_fault), .status_event(status_event),
    .cmd_ack(cmd_ack), .cmd_rdata(cmd_rdata), .cmd_busy(cmd_busy), .alert_n(alert_n),
    .vid_mode(vid_mode), .chan_on(chan_on), .chan_soft_off(chan_soft_off),
    .chan_setpoint(chan_setpoint), .chan_vid_mv(chan_vid_mv));
  pocr_host i_host (.core_clk(core_clk), .cmd_ack(cmd_ack), .cmd_busy(cmd_busy),
    .cmd_rdata(cmd_rdata), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  function logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function bit ok_wr(input int c);
    return wp == 0 || c == 16 || (wp == 32 && (c < 3 || c == 33)) || (wp == 64 && c < 2);
  endfunction
  // Start gating with the pin polarity latched at power-up
  function bit want(input int ch);
    return !cfg[ch][4] || ((!cfg[ch][3] || op[ch][7]) && (!cfg[ch][2] || channel_enable_pin[ch]));
  endfunction
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task wr(input int c, input int d);
    logic [15:0] r;
    bit a;
    int lo, hi;
    lo = 205 << scl;
    hi = 768 << scl;
    i_host.req(1'b1, c[7:0], d[15:0], 1'b0, r, a);
    chk("write ack", {15'h0, a}, 16'h1);
    // Stored copies of every channel, reloaded where unprotected
    if (c == 17) begin
      nop = op;
      ncfg = cfg;
      nvo = vo;
      nfmt = fmt;
    end
    if (c == 18) begin
      if (ok_wr(1)) op = nop;
      if (ok_wr(2)) cfg = ncfg;
      if (ok_wr(33)) vo = nvo;
      if (ok_wr(32)) fmt = nfmt;
    end
    if (ok_wr(c)) begin
      for (int ch = 0; ch < 2; ch++) if ((pg == 129 || pg == ch) && !chan_slave[ch]) begin
        if (c == 1) op[ch] = d & 192;
        if (c == 2) cfg[ch] = d & 31;
        if (c == 33 && (fmt == 33 ? (d < 256) : (d >= lo && d <= hi))) vo[ch] = d;
      end
      if (c == 0 && (d < 2 || d == 129)) pg = d;
      if (c == 16 && $countones(d & 224) < 2) wp = d & 224;
      if (c == 32 && (d == 23 || d == 33)) fmt = d;
    end
  endtask
  task rdc(input int c);
    logic [15:0] r;
    bit a;
    int ch, e;
    ch = (pg == 129) ? 0 : pg;
    e = c == 0 ? pg : c == 1 ? op[ch] : c == 2 ? cfg[ch] : c == 16 ? wp : c == 25 ? 208 :
        c == 32 ? fmt : vo[ch];
    i_host.req(1'b0, c[7:0], 16'h0000, 1'b0, r, a);
    chk("read data", r, e[15:0]);
    chk("read ack", {15'h0, a}, 16'h1);
  endtask
  task print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    print_verdict();
  end
  initial begin
    int v;
    logic [15:0] r;
    bit a;
    pg = 0;
    wp = 0;
    fmt = 23;
    scl = 0;
    op = '{128, 128};
    cfg = '{30, 30};
    vo = '{307, 307};
    nop = op;
    ncfg = cfg;
    nvo = vo;
    nfmt = fmt;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    nvm_clear = 1'b0;
    wt(8);
    foreach (cl[i]) rdc(cl[i]);
    chk("chan_on", {14'h0, chan_on}, 16'h3);
    $display("test reset values done");
    foreach (cv[i]) for (int k = 0; k < 4; k++) begin
      wr(2, cv[i]);
      wr(1, k[0] ? 128 : 0);
      channel_enable_pin[0] = k[1];
      wt(6);
      chk("start", {15'h0, chan_on[0]}, {15'h0, want(0)});
    end
    channel_enable_pin[0] = 1'b0;
    wt(6);
    chk("pin off soft", {15'h0, chan_soft_off[0]}, 16'h1);
    wr(2, 31);
    wt(4);
    chk("pin off hard", {15'h0, chan_soft_off[0]}, 16'h0);
    wr(2, 30);
    channel_enable_pin[0] = 1'b1;
    $display("test start gating done");
    wr(0, 1);
    wr(0, 128);
    rdc(0);
    wr(1, 64);
    wt(4);
    chk("chan_on", {14'h0, chan_on}, 16'h1);
    chk("soft_off", {15'h0, chan_soft_off[1]}, 16'h1);
    wr(1, 0);
    wt(4);
    chk("soft_off", {15'h0, chan_soft_off[1]}, 16'h0);
    wr(1, 192);
    wt(4);
    chk("chan_on", {14'h0, chan_on}, 16'h3);
    wr(33, 400);
    wr(0, 129);
    rdc(33);
    v = 205 + lf % 564;
    lf = nxt(lf);
    wr(33, v);
    wt(2);
    chk("setpoint1", chan_setpoint[15:0], vo[0][15:0]);
    chk("setpoint2", chan_setpoint[31:16], vo[1][15:0]);
    chan_slave = 2'b10;
    wt(3);
    wr(33, 600);
    wt(2);
    chk("slave", chan_setpoint[31:16], vo[1][15:0]);
    chk("master", chan_setpoint[15:0], vo[0][15:0]);
    chan_slave = 2'b00;
    wt(3);
    $display("test paging done");
    for (scl = 0; scl < 3; scl++) begin
      loop_scale_sel = scl[1:0];
      foreach (wl[i]) begin
        wr(33, ((i == 0 ? 205 : 768) << scl) + i - 1);
        rdc(33);
      end
      wr(33, 768 << scl);
      rdc(33);
    end
    scl = 0;
    loop_scale_sel = 2'b00;
    wr(32, 24);
    wr(32, 33);
    wr(33, 257);
    wr(33, 71);
    wt(3);
    chk("vid_mode", {15'h0, vid_mode}, 16'h1);
    chk("vid_mv", {4'h0, chan_vid_mv[11:0]}, 16'(245 + 5 * vo[0]));
    rdc(32);
    rdc(33);
    wr(32, 23);
    $display("test setpoint done");
    i_host.gap = 2;
    foreach (wl[i]) begin
      wr(16, wl[i]);
      foreach (cl[j]) if (cl[j] != 16 && cl[j] != 25) begin
        wr(cl[j], pv[j]);
        rdc(cl[j]);
      end
      wr(16, 96);
      rdc(16);
      wr(16, 0);
    end
    i_host.gap = 0;
    wr(1, 128);
    wr(2, 30);
    $display("test protection done");
    status_event = lf[7:0] | 8'h01;
    wt(6);
    chk("alert_n", {15'h0, alert_n}, 16'h0);
    wr(27, 16'hff7a);
    wt(3);
    chk("alert_n", {15'h0, alert_n}, 16'h1);
    wr(27, 16'h007a);
    status_event = 8'h00;
    wt(6);
    chk("alert_n", {15'h0, alert_n}, 16'h0);
    wr(3, 0);
    wt(3);
    chk("alert_n", {15'h0, alert_n}, 16'h1);
    wr(0, 0);
    chan_fault = 2'b01;
    wt(6);
    chk("fault off", {15'h0, chan_on[0]}, 16'h0);
    chan_fault = 2'b00;
    wr(3, 0);
    wt(6);
    chk("clear no start", {15'h0, chan_on[0]}, 16'h0);
    wr(1, 128);
    wt(4);
    chk("on alone", {15'h0, chan_on[0]}, 16'h0);
    i_host.restart();
    wt(4);
    chk("restart", {15'h0, chan_on[0]}, 16'h1);
    $display("test faults done");
    wr(17, 0);
    chk("busy", {15'h0, cmd_busy}, 16'h1);
    i_host.req(1'b0, 8'h19, 16'h0000, 1'b1, r, a);
    chk("refused", {15'h0, a}, 16'h0);
    wr(1, 0);
    wr(16, 128);
    wr(18, 0);
    rdc(1);
    wr(16, 0);
    wr(18, 0);
    rdc(1);
    wr(0, 1);
    foreach (cl[i]) rdc(cl[i]);
    $display("test store done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
